// ==== pkg/tbcsp_pkg.sv ====
package tbcsp_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  localparam logic [7:0] OFS_CMPL = 8'h10;
  localparam logic [7:0] OFS_CMPH = 8'h14;
  localparam logic [7:0] OFS_CMPW = 8'h18;
  localparam int B_EN = 0;
  localparam int B_MODE = 1;
  localparam int B_PINEN = 4;
  localparam int B_PINIT = 5;
  localparam int B_IMM = 6;
  localparam int B_POL = 7;
  localparam int B_UPPER = 8;
  localparam int B_TSRC = 9;
  localparam int B_CAPEN = 10;
  localparam int F_MATCH = 0;
  localparam int F_WRAP = 1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int SYNC_DLY = 2;
  localparam int LOW_TICKS = 1;
  localparam int EDGE_SEP = 2;
  typedef enum logic [2:0] {
    TBCSP_M_PERIODIC, TBCSP_M_TIMEOUT, TBCSP_M_MATCH_EVENT_FLAG_EVT, TBCSP_M_FRQ,
    TBCSP_M_PW, TBCSP_M_FRQPW, TBCSP_M_SHOT, TBCSP_M_PWM
  } tbcsp_mode_t;
  typedef enum logic [1:0] {
    TBCSP_S_IDLE, TBCSP_S_HIGH, TBCSP_S_WAIT
  } tbcsp_phase_t;
endpackage

// ==== rtl/tbcsp_edge.sv ====
`timescale 1ns/100ps
`default_nettype none
module tbcsp_edge (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic prev_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level;
    end
  end
  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;
endmodule
`default_nettype wire

// ==== rtl/tbcsp_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R01: Frequency mode: capture count, restart on edge
// R02: Match flag clears on compare low read
// R03: Capture modes: wrap flag, event at max
// R04: Pulse mode: restart rising, capture falling
// R05: Pulse mode alternates edges, two cycles apart
// R06: Combined: start rise, capture fall, stop
// R07: Combined: low read rearms, zero next rise
// R08: Shot: low when stopped, trigger runs high
// R09: Shot end: low one tick, triggers ignored
// R10: New trigger output high two cycles later
// R11: Polarity one: either edge; zero: rising
// R12: Shot starts on enable or polarity change
// R13: Immediate trigger sets output, count later
// R14: Counting flag shows shot counter running
// R15: PWM counts zero to period, clears duty
// R16: PWM period plus one, high duty
// R17: Immediate trigger lengthens high by delay cycles
// R18: Pin drive enable gates waveform to pin
// R19: Other modes use pin start level
// R20: Software avoids mode change, clears flags
// R21: Lower counter wraps, upper counts wraps
// R22: Lower uses upper select zero, shared event
// R23: Counter range zero to all ones
// R24: Upper uses events as tick; concatenated
// R25: One edge updates all same cycle
// R26: Wrap event is one clock pulse
module tbcsp_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tbcsp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [tbcsp_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tbcsp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [tbcsp_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic counter_tick,
  input wire logic capture_event,
  input wire logic count_event,
  output logic match_event,
  output logic wrap_event,
  output logic waveform,
  output logic pin_drive,
  output logic pin_value
);
  import tbcsp_pkg::*;

  logic [10:0] ctrl_q;
  logic [15:0] count_q, cmp_q;
  logic [1:0] flags_q;
  logic [7:0] cmp_hi_lat_q;
  logic aw_q, w_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [1:0] bresp_q, rresp_q;
  logic pw_high_q, armed_q, fp_run_q, fp_done_q, out_q;
  tbcsp_phase_t phase_q;
  logic [1:0] trig_dly_q;
  logic trig_pend_q, low_seen_q, pol_q, en_q;
  logic ev_rise, ev_fall, ev_any;

  tbcsp_mode_t mode;
  logic enabled, tick, wr_fire, rd_fire, cmp_lo_rd;
  logic wr_ctrl, wr_count, wr_cmp, wr_flags;
  logic at_max, cap_mode, shot_trig, restart, capture, match_set;

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a,
      input logic [7:0] ofs);
    return a == ofs;
  endfunction

  tbcsp_edge u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(capture_event),
    .rise(ev_rise),
    .fall(ev_fall)
  );
  assign ev_any = ev_rise | ev_fall;

  assign mode = tbcsp_mode_t'(ctrl_q[B_MODE +: 3]);
  assign enabled = ctrl_q[B_EN];
  // R24: upper half ticks on events
  assign tick = ctrl_q[B_TSRC] ? count_event : counter_tick;
  // R23: top of range
  assign at_max = count_q == CNT_MAX;
  assign cap_mode = mode inside {TBCSP_M_MATCH_EVENT_FLAG_EVT, TBCSP_M_FRQ, TBCSP_M_PW,
                                 TBCSP_M_FRQPW, TBCSP_M_TIMEOUT};

  // AXI4-Lite slave
  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready = !w_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign wr_fire = aw_q && w_q && !bvalid_q;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_ctrl = wr_fire && hit(awaddr_q, OFS_CTRL);
  assign wr_count = wr_fire && hit(awaddr_q, OFS_COUNT);
  assign wr_cmp = wr_fire && (hit(awaddr_q, OFS_CMPL) ||
                              hit(awaddr_q, OFS_CMPH) ||
                              hit(awaddr_q, OFS_CMPW));
  assign wr_flags = wr_fire && hit(awaddr_q, OFS_FLAGS);
  // R02: low byte read side effect
  assign cmp_lo_rd = rd_fire && (hit(s_axi_araddr, OFS_CMPL) ||
                                 hit(s_axi_araddr, OFS_CMPW));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
      end
      if (wr_fire) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_ctrl | wr_count | wr_cmp | wr_flags) ?
                   RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      cmp_hi_lat_q <= '0;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
      unique case (s_axi_araddr)
        OFS_CTRL: rdata_q <= {21'h0, ctrl_q};
        // R14: running indication
        OFS_STATUS: rdata_q <= {31'h0, phase_q == TBCSP_S_HIGH};
        OFS_FLAGS: rdata_q <= {30'h0, flags_q};
        OFS_COUNT: rdata_q <= {16'h0, count_q};
        OFS_CMPL: begin
          rdata_q <= {24'h0, cmp_q[7:0]};
          cmp_hi_lat_q <= cmp_q[15:8];
        end
        OFS_CMPH: rdata_q <= {24'h0, cmp_hi_lat_q};
        OFS_CMPW: rdata_q <= {16'h0, cmp_q};
        default: rresp_q <= RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '0;
    end else if (wr_ctrl) begin
      ctrl_q <= wdata_q[10:0];
    end
  end

  // Capture mode event decode
  always_comb begin
    restart = 1'b0;
    capture = 1'b0;
    match_set = 1'b0;
    if (enabled && ctrl_q[B_CAPEN]) begin
      unique case (mode)
        // R01: either selected edge
        TBCSP_M_FRQ, TBCSP_M_MATCH_EVENT_FLAG_EVT: begin
          capture = ctrl_q[B_POL] ? ev_fall : ev_rise;
          restart = (mode == TBCSP_M_FRQ) && capture;
          match_set = capture;
        end
        // R04: restart rising, capture falling
        TBCSP_M_PW: begin
          restart = ev_rise;
          capture = ev_fall && pw_high_q;
          match_set = capture;
        end
        // R06: start, capture, stop sequence
        TBCSP_M_FRQPW: begin
          restart = ev_rise && armed_q && !fp_run_q;
          capture = ev_fall && fp_run_q && !fp_done_q;
          match_set = ev_rise && fp_run_q;
        end
        default: begin
          restart = 1'b0;
        end
      endcase
    end
  end

  // R05: edge alternation tracker
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pw_high_q <= 1'b0;
    end else if (ev_rise) begin
      pw_high_q <= 1'b1;
    end else if (ev_fall) begin
      pw_high_q <= 1'b0;
    end
  end

  // R07: rearm on compare low read
  always_ff @(posedge aclk) begin
    if (!aresetn || !enabled || mode != TBCSP_M_FRQPW) begin
      armed_q <= 1'b1;
      fp_run_q <= 1'b0;
      fp_done_q <= 1'b0;
    end else begin
      if (restart) begin
        fp_run_q <= 1'b1;
        fp_done_q <= 1'b0;
        armed_q <= 1'b0;
      end else if (match_set) begin
        fp_run_q <= 1'b0;
      end else if (capture) begin
        fp_done_q <= 1'b1;
      end
      if (cmp_lo_rd && !restart) begin
        armed_q <= 1'b1;
      end
    end
  end

  // R11: trigger edge selection
  assign shot_trig = enabled && mode == TBCSP_M_SHOT && ctrl_q[B_CAPEN] &&
                     (ctrl_q[B_POL] ? ev_any : ev_rise);

  // Single-shot sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= TBCSP_S_IDLE;
      trig_dly_q <= '0;
      trig_pend_q <= 1'b0;
      low_seen_q <= 1'b0;
      en_q <= 1'b0;
      pol_q <= 1'b0;
    end else begin
      en_q <= enabled;
      pol_q <= ctrl_q[B_POL];
      if (!enabled || mode != TBCSP_M_SHOT) begin
        phase_q <= TBCSP_S_IDLE;
        trig_pend_q <= 1'b0;
      end else begin
        unique case (phase_q)
          TBCSP_S_IDLE: begin
            // R12: spurious start on enable
            if ((!en_q || pol_q != ctrl_q[B_POL]) && !at_max) begin
              phase_q <= TBCSP_S_HIGH;
            end else if (shot_trig) begin
              // R10: two cycle start delay
              trig_pend_q <= 1'b1;
              trig_dly_q <= 2'(SYNC_DLY - 1);
            end else if (trig_pend_q) begin
              if (trig_dly_q == '0) begin
                trig_pend_q <= 1'b0;
                phase_q <= TBCSP_S_HIGH;
              end else begin
                trig_dly_q <= trig_dly_q - 2'd1;
              end
            end
          end
          TBCSP_S_HIGH: begin
            // R09: stop at compare
            if (tick && count_q == cmp_q) begin
              phase_q <= TBCSP_S_WAIT;
              low_seen_q <= 1'b0;
            end
          end
          TBCSP_S_WAIT: begin
            // R09: triggers ignored for a tick
            if (tick) begin
              phase_q <= TBCSP_S_IDLE;
            end
          end
          default: phase_q <= TBCSP_S_IDLE;
        endcase
      end
    end
  end

  // Counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= CNT_BOTTOM;
    end else if (wr_count) begin
      count_q <= wdata_q[15:0];
    // R25: restart in capture cycle
    end else if (restart) begin
      count_q <= CNT_BOTTOM;
    end else if (enabled) begin
      unique case (mode)
        // R08: counter reset on trigger
        TBCSP_M_SHOT: begin
          if (phase_q == TBCSP_S_IDLE && trig_pend_q && trig_dly_q == '0) begin
            count_q <= CNT_BOTTOM;
          end else if (phase_q == TBCSP_S_HIGH && tick &&
                       count_q != cmp_q) begin
            count_q <= count_q + 16'd1;
          end
        end
        // R15: wrap at period byte
        TBCSP_M_PWM: begin
          if (tick) begin
            count_q <= (count_q[7:0] >= cmp_q[7:0]) ? CNT_BOTTOM :
                       count_q + 16'd1;
          end
        end
        TBCSP_M_FRQPW: begin
          if (tick && fp_run_q) begin
            count_q <= count_q + 16'd1;
          end
        end
        // R21: lower wraps at max
        default: begin
          if (tick) begin
            count_q <= at_max ? CNT_BOTTOM : count_q + 16'd1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_q <= '0;
    end else if (capture) begin
      cmp_q <= count_q;
    end else if (wr_cmp) begin
      if (hit(awaddr_q, OFS_CMPH)) begin
        cmp_q[15:8] <= wdata_q[7:0];
      end else if (hit(awaddr_q, OFS_CMPL)) begin
        cmp_q[7:0] <= wdata_q[7:0];
      end else begin
        cmp_q <= wdata_q[15:0];
      end
    end
  end

  // R03: wrap event in capture modes
  // R26: single cycle wrap pulse
  assign wrap_event = enabled && cap_mode && tick && at_max;
  assign match_event = match_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= '0;
    end else begin
      if (wr_flags) begin
        flags_q <= flags_q & ~wdata_q[1:0];
      end
      // R02: read clears unless event now
      if (cmp_lo_rd && cap_mode) begin
        flags_q[F_MATCH] <= 1'b0;
      end
      if (match_set) begin
        flags_q[F_MATCH] <= 1'b1;
      end
      if (wrap_event) begin
        flags_q[F_WRAP] <= 1'b1;
      end
    end
  end

  // Waveform generator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= 1'b0;
    end else begin
      unique case (mode)
        TBCSP_M_SHOT: begin
          if (!enabled || phase_q == TBCSP_S_WAIT) begin
            out_q <= 1'b0;
          end else if (phase_q == TBCSP_S_HIGH) begin
            out_q <= !(tick && count_q == cmp_q);
          end else if (trig_pend_q && trig_dly_q == '0) begin
            out_q <= 1'b1;
          end
        end
        // R16: high duty ticks of period plus one
        TBCSP_M_PWM: begin
          if (enabled && tick) begin
            if (count_q[7:0] >= cmp_q[7:0]) begin
              out_q <= cmp_q[15:8] != 8'h00;
            end else if (count_q[7:0] + 8'd1 >= cmp_q[15:8]) begin
              out_q <= 1'b0;
            end
          end
        end
        // R19: start level
        default: out_q <= ctrl_q[B_PINIT];
      endcase
    end
  end

  // R13: immediate set on trigger edge
  // R17: high extended by sync delay
  assign waveform = out_q | (mode == TBCSP_M_SHOT && ctrl_q[B_IMM] &&
                    phase_q == TBCSP_S_IDLE && (shot_trig || trig_pend_q));
  // R18: pin override
  assign pin_drive = ctrl_q[B_PINEN];
  assign pin_value = ctrl_q[B_PINEN] & waveform;
endmodule
`default_nettype wire

// ==== verif/tbcsp_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module tbcsp_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic capture_event,
  input wire logic match_event,
  input wire logic wrap_event,
  input wire logic waveform,
  input wire logic pin_drive,
  input wire logic pin_value
);
  import tbcsp_pkg::*;
  logic [10:0] ctl_q;
  logic [2:0] md;
  logic wr_ctl;
  assign md = ctl_q[3:1];
  assign wr_ctl = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && s_axi_awaddr == OFS_CTRL;
  // Shadow of the control word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= '0;
    end else if (wr_ctl) begin
      ctl_q <= s_axi_wdata[10:0];
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_wrap_single: assert property (wrap_event |=> !wrap_event)
    else $error("wrap event too long");
  a_wrap_mode: assert property (wrap_event |-> ctl_q[0] &&
    md inside {3'd2, 3'd3, 3'd4, 3'd5}) else $error("wrap out of mode");
  a_pin_follow: assert property (pin_value ==
    (pin_drive && waveform)) else $error("pin not following waveform");
  a_freq_capture: assert property (ctl_q[0] && ctl_q[B_CAPEN] &&
    md == 3'd3 && !ctl_q[B_POL] && $rose(capture_event)
    |-> match_event) else $error("no capture on edge");
  a_pw_rise_quiet: assert property (ctl_q[0] && md == 3'd4 &&
    $rose(capture_event) |-> !match_event [*2])
    else $error("match on rising edge");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("late read answer");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("late write answer");
  a_write_refuse: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
endmodule
`default_nettype wire

// ==== verif/tbcsp_evt_src.sv ====
`timescale 1ns/100ps
`default_nettype none
module tbcsp_evt_src (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic lvl,
  input wire logic cnt_req,
  input wire logic wrap_in,
  output logic capture_event,
  output logic count_event
);
  import tbcsp_pkg::*;
  logic [3:0] gap_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_event <= 1'b0;
      gap_q <= '0;
    end else if (lvl != capture_event && gap_q >= EDGE_SEP) begin
      capture_event <= lvl;
      gap_q <= '0;
    end else if (gap_q != 4'hF) begin
      gap_q <= gap_q + 4'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_event <= 1'b0;
    end else begin
      count_event <= wrap_in | cnt_req;
    end
  end
endmodule
`default_nettype wire

// ==== verif/test_tbcsp_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_tbcsp_top;
  import tbcsp_pkg::*;
  localparam logic [31:0] ONE = 32'h0000_0001;
  logic aclk, aresetn, lvl, cnt_req, awvalid, wvalid, bready, ctick, slow;
  logic arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic capture_event, count_event, match_event, wrap_event;
  logic waveform, pin_drive, pin_value;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, a, b;
  logic [1:0] bresp, rresp, rsp;
  int failures, compares, cyc, t0, t1, t2, n, h, h2, i;
  tbcsp_top i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .counter_tick(ctick),
    .capture_event(capture_event), .count_event(count_event),
    .match_event(match_event), .wrap_event(wrap_event),
    .waveform(waveform), .pin_drive(pin_drive), .pin_value(pin_value));
  tbcsp_evt_src i_src (
    .aclk(aclk), .aresetn(aresetn), .lvl(lvl), .cnt_req(cnt_req),
    .wrap_in(wrap_event), .capture_event(capture_event),
    .count_event(count_event));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic stp;
    @(posedge aclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= ad;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] v);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        v = rdata;
        rsp = rresp;
        break;
      end
    end
  endtask
  function automatic logic [31:0] cw(input logic [2:0] m,
    input logic [31:0] x);
    return x | (32'(m) << B_MODE) | (ONE << B_CAPEN) | ONE;
  endfunction
  task automatic pls(input int w, output int t);
    @(posedge aclk);
    lvl <= 1'b1;
    t = cyc;
    repeat (w) @(posedge aclk);
    lvl <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic shot(output int dly, output int hi);
    @(posedge aclk);
    lvl <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(waveform, 1'b0);
    lvl <= 1'b1;
    @(posedge capture_event);
    #1;
    dly = 0;
    hi = 0;
    while (waveform !== 1'b1) begin stp(); dly++; end
    while (waveform === 1'b1) begin stp(); hi++; end
  endtask
  task automatic meas(output int hi, output int lo);
    hi = 0;
    lo = 0;
    while (waveform === 1'b1) stp();
    while (waveform !== 1'b1) stp();
    while (waveform === 1'b1) begin stp(); hi++; end
    while (waveform !== 1'b1) begin stp(); lo++; end
  endtask
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;
  // Tick every cycle, or every other cycle when slow
  always @(posedge aclk) ctick <= !(slow && ctick);
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    test_done();
  end
  initial begin
    {aresetn, lvl, cnt_req, awvalid, wvalid, bready, arvalid, rready} = '0;
    slow = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    cyc = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_CTRL, d);
    chk(d, 32'h0000_0000);
    rd(8'h1C, d);
    chk(rsp, RESP_SLVERR);
    $display("registers done");
    wr(OFS_CTRL, cw(TBCSP_M_FRQ, (ONE << B_PINEN) | (ONE << B_PINIT)));
    wr(OFS_FLAGS, 32'h0000_0003);
    chk(pin_value, 1'b1);
    pls(4, t0);
    repeat (12) @(posedge aclk);
    pls(4, t1);
    rd(OFS_FLAGS, d);
    chk(d[0], 1'b1);
    rd(OFS_CMPW, a);
    rd(OFS_FLAGS, d);
    chk(d[0], 1'b0);
    pls(4, t2);
    rd(OFS_CMPW, b);
    chk(b - a, 32'((t2 - t1) - (t1 - t0)));
    $display("frequency done");
    wr(OFS_CTRL, cw(TBCSP_M_PW, 32'h0000_0000));
    pls(6, t0);
    rd(OFS_CMPW, a);
    pls(16, t0);
    rd(OFS_CMPW, b);
    chk(b - a, 32'h0000_000A);
    $display("pulse width done");
    wr(OFS_CTRL, cw(TBCSP_M_FRQPW, 32'h0000_0000));
    rd(OFS_CMPW, d);
    pls(6, t0);
    repeat (10) @(posedge aclk);
    pls(6, t1);
    rd(OFS_COUNT, a);
    repeat (8) @(posedge aclk);
    rd(OFS_COUNT, d);
    chk(d, a);
    rd(OFS_CMPW, a);
    pls(12, t0);
    repeat (10) @(posedge aclk);
    pls(6, t1);
    rd(OFS_CMPW, b);
    chk(b - a, 32'h0000_0006);
    $display("combined done");
    wr(OFS_CTRL, cw(TBCSP_M_MATCH_EVENT_FLAG_EVT, 32'h0000_0000));
    wr(OFS_COUNT, 32'h0000_FFF0);
    i = 0;
    while (wrap_event !== 1'b1 && i < 40) begin stp(); i++; end
    chk(i < 40, 1'b1);
    rd(OFS_FLAGS, d);
    chk(d[F_WRAP], 1'b1);
    wr(OFS_FLAGS, ONE << F_WRAP);
    rd(OFS_FLAGS, d);
    chk(d[F_WRAP], 1'b0);
    wr(OFS_CTRL, cw(TBCSP_M_MATCH_EVENT_FLAG_EVT, ONE << B_TSRC));
    wr(OFS_COUNT, 32'h0000_0000);
    for (i = 0; i < 5; i++) begin
      @(posedge aclk);
      cnt_req <= 1'b1;
      @(posedge aclk);
      cnt_req <= 1'b0;
    end
    repeat (3) @(posedge aclk);
    rd(OFS_COUNT, d);
    chk(d, 32'h0000_0005);
    $display("wrap done");
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CMPW, 32'h0000_0014);
    wr(OFS_COUNT, 32'h0000_FFFF);
    wr(OFS_CTRL, cw(TBCSP_M_SHOT, ONE << B_PINEN));
    repeat (8) @(posedge aclk);
    chk(waveform, 1'b0);
    shot(n, h);
    // Counted from the edge before the event is sampled
    chk(n, SYNC_DLY + 1);
    rd(OFS_STATUS, d);
    chk(d[0], 1'b0);
    wr(OFS_CMPW, 32'h0000_001E);
    shot(n, h2);
    chk(h2 - h, 32'h0000_000A);
    wr(OFS_CTRL, cw(TBCSP_M_SHOT, (ONE << B_PINEN) | (ONE << B_IMM)));
    shot(n, h);
    chk(n, 32'h0000_0000);
    chk(h - h2, SYNC_DLY + 1);
    chk((h - 30) inside {3, 4}, 1'b1);
    wr(OFS_COUNT, 32'h0000_0000);
    wr(OFS_CTRL, cw(TBCSP_M_SHOT, ONE << B_POL));
    rd(OFS_STATUS, d);
    chk(d[0], 1'b1);
    repeat (40) @(posedge aclk);
    lvl <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(waveform, 1'b1);
    $display("single shot done");
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CMPW, 32'h0000_0309);
    wr(OFS_CTRL, cw(TBCSP_M_PWM, ONE << B_PINEN));
    meas(h, n);
    chk(h, 32'h0000_0003);
    chk(h + n, 32'h0000_000A);
    @(posedge aclk);
    slow <= 1'b1;
    meas(h, n);
    chk(h, 32'h0000_0006);
    chk(h + n, 32'h0000_0014);
    @(posedge aclk);
    slow <= 1'b0;
    wr(OFS_CTRL, cw(TBCSP_M_PWM, 32'h0000_0000));
    h = 0;
    repeat (12) begin
      stp();
      if (pin_value !== 1'b0) h++;
    end
    chk(h, 32'h0000_0000);
    chk(pin_drive, 1'b0);
    $display("pwm done");
    test_done();
  end
endmodule
bind tbcsp_top tbcsp_props i_props (.*);
`default_nettype wire
